/* cwt_params.svh */
`ifndef CWT_PARAMS_SVH
`define CWT_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define CWT_IDX_SERVICE 16'hffff
`define CWT_IDX_CONFIG 16'h0001
`define CWT_IDX_STATUS 16'h0002
`define CWT_ADDR_W 18

// Config register fields.
`define CWT_CFG_RATE 0
`define CWT_CFG_DISABLE 1
`define CWT_CFG_STOP_EN 2
`define CWT_CFG_RESET 3'h0

// Status register fields.
`define CWT_ST_FLAG 0
`define CWT_ST_LOCK 1
`define CWT_ST_ENABLED 2
`define CWT_ST_CTR_LSB 8
`define CWT_ST_PRE_LSB 16

// Counter structure.
`define CWT_PRE_W 12
`define CWT_CTR_W 6
`define CWT_MASK_LONG 12'hfff
`define CWT_MASK_SHORT 12'h07f
`define CWT_KEEP_LOW 12'h00f

// Timing in oscillator clock cycles.
`define CWT_TIMEOUT_LONG 262128
`define CWT_TIMEOUT_SHORT 8176
`define CWT_RST_PULSE 32
`define CWT_POR_DELAY 4096

`endif

/* cwt_pkg.sv */
package cwt_pkg;

  typedef struct packed {
    logic stop_en;
    logic disable_wd;
    logic rate_short;
  } cwt_cfg_t;

  typedef struct packed {
    logic monitor_entry;
    logic vectors_blank;
    logic break_active;
    logic stop_exec;
    logic stop_mode;
    logic internal_reset;
    logic vector_fetch;
  } cwt_sys_t;

  typedef enum logic {
    CWT_RUN,
    CWT_PULSE
  } cwt_state_t;

endpackage

/* cwt_sys_model.sv */
`timescale 1ns/100ps

module cwt_sys_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Reset pin
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  // Seen by reset logic
  output int n_rise,
  output int pulse_len
);
  // The pin has a pull-up, so a released pin reads high.
  wire pin = reset_pin_oe ? reset_pin_out : 1'b1;
  logic last;
  int run;

  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      last <= 1'b1;
      run <= 0;
      n_rise <= 0;
      pulse_len <= 0;
    end
    else
    begin
      last <= pin;
      run <= pin ? 0 : run + 1;
      if (!pin && last)
        n_rise <= n_rise + 1;
      if (pin && !last)
        pulse_len <= run;
    end
endmodule // cwt_sys_model

/* cwt_watchdog.sv */
// How it works
// - 12-bit prescaler on oscillator clock feeds 6-bit counter
// - Unserviced overflow resets after 262128 or 8176 cycles
// - Overflow drives reset pin 32 cycles, sets flag
// - Monitor entry with high voltage disables while present
// - Blank-vector monitor entry disables until power-on reset
// - Break with high voltage on reset pin disables
// - Stop clears prescaler and halts oscillator clock
// - Power-on logic clears prescaler after 4096 cycles
// - Internal reset clears prescaler and counter
// - Reset vector fetch clears the prescaler
// - Reading service address returns reset vector low byte
// - Disable input asserted means no watchdog reset ever
// - No interrupt request; reset is only action
// - Counting continues in wait mode
// - Stop when disabled gives illegal opcode reset
// - Each service starts new period; low four prescaler bits kept
// - Rate select one short, zero long; reset clears
// - Disable bit one disables, zero enables
// - Stop enable zero makes stop illegal
`timescale 1ns/100ps
`include "cwt_params.svh"

module cwt_watchdog
#(
  parameter int OSC_DIV = 1,
  parameter int POR_DELAY = `CWT_POR_DELAY
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CWT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System side
  input wire cwt_pkg::cwt_sys_t sys_in,
  input wire logic [7:0] reset_vector_low,
  // Test high voltage detectors on the pins
  input wire logic irq_hv_pin,
  input wire logic rst_hv_pin,
  // Reset outputs
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic watchdog_reset,
  output logic illegal_opcode_reset
);
  import cwt_pkg::*;

  function automatic logic cwt_hit(input logic [`CWT_ADDR_W-1:0] a, input logic [15:0] idx);
    cwt_hit = (a[`CWT_ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [11:0] cwt_mask(input logic rate_short);
    cwt_mask = rate_short ? `CWT_MASK_SHORT : `CWT_MASK_LONG;
  endfunction

  logic [15:0] div_cnt;
  logic osc_tick;
  logic [12:0] por_cnt;
  logic por_done;
  logic por_clear;
  logic irq_hv_meta;
  logic irq_hv;
  logic rst_hv_meta;
  logic rst_hv;
  cwt_cfg_t cfg;
  logic cfg_locked;
  logic mon_hv;
  logic mon_blank;
  logic enabled;
  logic running;
  logic count_tick;
  logic [`CWT_PRE_W-1:0] pre;
  logic [`CWT_PRE_W-1:0] next_pre;
  logic [`CWT_CTR_W-1:0] ctr;
  logic [11:0] mask;
  logic wrap;
  logic fire;
  cwt_state_t state;
  logic [4:0] pulse_cnt;
  logic wd_flag;
  logic access;
  logic setup;
  logic wr_service;
  logic wr_config;
  logic wr_status;
  logic mapped;
  logic clear_all;
  logic stop_ok;
  logic [31:0] next_rdata;

  // The oscillator clock is an enable pulse derived from pclk.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 16'h0000;
    else if (osc_tick)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  assign osc_tick = (div_cnt == 16'(OSC_DIV - 1));

  // Power-up delay; the prescaler is cleared once it expires.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_cnt <= 13'h0000;
      por_done <= 1'b0;
    end
    else if (osc_tick && !por_done)
    begin
      por_cnt <= por_cnt + 13'h0001;
      if (por_cnt == 13'(POR_DELAY - 1))
        por_done <= 1'b1;
    end
  end

  assign por_clear = osc_tick && !por_done && (por_cnt == 13'(POR_DELAY - 1));

  // Pin detectors are asynchronous to pclk.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_hv_meta <= 1'b0;
      irq_hv <= 1'b0;
      rst_hv_meta <= 1'b0;
      rst_hv <= 1'b0;
    end
    else
    begin
      irq_hv_meta <= irq_hv_pin;
      irq_hv <= irq_hv_meta;
      rst_hv_meta <= rst_hv_pin;
      rst_hv <= rst_hv_meta;
    end
  end

  // APB decode. The slave answers with no wait states.
  assign access = psel && penable;
  assign setup = psel && !penable;
  assign mapped = cwt_hit(paddr, `CWT_IDX_SERVICE) || cwt_hit(paddr, `CWT_IDX_CONFIG)
    || cwt_hit(paddr, `CWT_IDX_STATUS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_service = access && pwrite && cwt_hit(paddr, `CWT_IDX_SERVICE);
  assign wr_config = access && pwrite && cwt_hit(paddr, `CWT_IDX_CONFIG);
  assign wr_status = access && pwrite && cwt_hit(paddr, `CWT_IDX_STATUS);

  // Configuration is write-once after each reset, as the options latch.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= `CWT_CFG_RESET;
      cfg_locked <= 1'b0;
    end
    else if (sys_in.internal_reset || fire)
    begin
      cfg <= `CWT_CFG_RESET;
      cfg_locked <= 1'b0;
    end
    else if (wr_config && !cfg_locked)
    begin
      cfg.rate_short <= pwdata[`CWT_CFG_RATE];
      cfg.disable_wd <= pwdata[`CWT_CFG_DISABLE];
      cfg.stop_en <= pwdata[`CWT_CFG_STOP_EN];
      cfg_locked <= 1'b1;
    end
  end

  // Monitor-mode entry conditions. The blank-vector case survives
  // internal resets on purpose; only power-on clears it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_blank <= 1'b0;
    else if (sys_in.monitor_entry && sys_in.vectors_blank && !irq_hv)
      mon_blank <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_hv <= 1'b0;
    else if (sys_in.monitor_entry)
      mon_hv <= irq_hv;
    else if (!irq_hv && !rst_hv)
      mon_hv <= 1'b0;
  end

  assign enabled = !cfg.disable_wd
    && !mon_hv
    && !mon_blank
    && !(sys_in.break_active && rst_hv);

  // Stop mode gates the oscillator clock; wait mode does not.
  assign running = enabled && !sys_in.stop_mode && (state == CWT_RUN);
  assign count_tick = osc_tick && running;
  assign mask = cwt_mask(cfg.rate_short);
  assign wrap = ((pre & mask) == mask);
  assign next_pre = pre + 12'h001;

  // Overflow lands where the timeout leaves the low four stages at zero,
  // which is why the periods fall 16 cycles short of a power of two.
  assign fire = count_tick && (ctr == 6'h3f)
    && ((next_pre & mask) == (mask & ~`CWT_KEEP_LOW));

  assign stop_ok = sys_in.stop_exec && cfg.stop_en;
  assign clear_all = sys_in.internal_reset || fire || !enabled;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre <= 12'h000;
    else if (clear_all)
      pre <= 12'h000;
    else if (stop_ok || sys_in.stop_mode)
      pre <= 12'h000;
    else if (por_clear)
      pre <= 12'h000;
    else if (sys_in.vector_fetch)
      pre <= 12'h000;
    else if (wr_service)
      pre <= pre & `CWT_KEEP_LOW;
    else if (count_tick)
      pre <= next_pre;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctr <= 6'h00;
    else if (clear_all || wr_service)
      ctr <= 6'h00;
    else if (count_tick && wrap)
      ctr <= ctr + 6'h01;
  end

  // Reset pulse on the pin, timed in oscillator cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CWT_RUN;
      pulse_cnt <= 5'h00;
    end
    else
    begin
      case (state)
        CWT_RUN:
        begin
          if (fire)
          begin
            state <= CWT_PULSE;
            pulse_cnt <= 5'h00;
          end
        end
        CWT_PULSE:
        begin
          if (osc_tick)
          begin
            pulse_cnt <= pulse_cnt + 5'h01;
            if (pulse_cnt == 5'(`CWT_RST_PULSE - 1))
              state <= CWT_RUN;
          end
        end
        default:
          state <= CWT_RUN;
      endcase
    end
  end

  // Open-drain reset pin: driven low only during the pulse.
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (state == CWT_PULSE);
  assign watchdog_reset = (state == CWT_PULSE);

  // Reset cause flag; a new overflow wins over a software clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_flag <= 1'b0;
    else if (fire)
      wd_flag <= 1'b1;
    else if (wr_status && pwdata[`CWT_ST_FLAG])
      wd_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      illegal_opcode_reset <= 1'b0;
    else
      illegal_opcode_reset <= sys_in.stop_exec && !cfg.stop_en;
  end

  // Read data is captured in the setup cycle so that it comes from a flop.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (cwt_hit(paddr, `CWT_IDX_SERVICE))
      next_rdata[7:0] = reset_vector_low;
    else if (cwt_hit(paddr, `CWT_IDX_CONFIG))
    begin
      next_rdata[`CWT_CFG_RATE] = cfg.rate_short;
      next_rdata[`CWT_CFG_DISABLE] = cfg.disable_wd;
      next_rdata[`CWT_CFG_STOP_EN] = cfg.stop_en;
    end
    else if (cwt_hit(paddr, `CWT_IDX_STATUS))
    begin
      next_rdata[`CWT_ST_FLAG] = wd_flag;
      next_rdata[`CWT_ST_LOCK] = cfg_locked;
      next_rdata[`CWT_ST_ENABLED] = enabled;
      next_rdata[`CWT_ST_CTR_LSB +: `CWT_CTR_W] = ctr;
      next_rdata[`CWT_ST_PRE_LSB +: `CWT_PRE_W] = pre;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= next_rdata;
  end

endmodule // cwt_watchdog

/* cwt_watchdog_properties.sv */
`timescale 1ns/100ps
`include "cwt_params.svh"

module cwt_watchdog_properties
#(
  parameter int OSC_DIV = 1,
  parameter int POR_DELAY = `CWT_POR_DELAY
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CWT_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  // System side
  input wire cwt_pkg::cwt_sys_t sys_in,
  input wire logic [7:0] reset_vector_low,
  // Reset outputs
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic watchdog_reset,
  input wire logic illegal_opcode_reset
);
  import cwt_pkg::*;
  int pulse_cnt;
  int since_svc;
  wire svc_wr = psel && penable && pwrite && paddr[17:2] == `CWT_IDX_SERVICE;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pulse_cnt <= 0;
    else if (watchdog_reset)
      pulse_cnt <= pulse_cnt + 1;
    else
      pulse_cnt <= 0;

  // Only a floor is safe: a service keeps the four low prescaler bits.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_svc <= 0;
    else if (svc_wr || watchdog_reset)
      since_svc <= 0;
    else if (since_svc < 32'h100000)
      since_svc <= since_svc + 1;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pulse_width:
    assert property ($fell(watchdog_reset) |-> pulse_cnt == `CWT_RST_PULSE * OSC_DIV)
      else $error("reset pulse length wrong");
  a_pin_drive:
    assert property (reset_pin_oe == watchdog_reset && !reset_pin_out)
      else $error("reset pin not driven low with the pulse");
  a_pulse_holds:
    assert property ($rose(reset_pin_oe) |-> (reset_pin_oe && !reset_pin_out) [*8])
      else $error("reset pin released too soon");
  a_timeout_floor:
    assert property ($rose(watchdog_reset) |-> since_svc >= `CWT_TIMEOUT_SHORT - 16)
      else $error("reset came too early");
  a_restart_gap:
    assert property ($fell(watchdog_reset) |=> (!watchdog_reset) [*8])
      else $error("counting did not restart cleared");
  a_ireset_quiet:
    assert property (sys_in.internal_reset |=> (!$rose(watchdog_reset)) [*8])
      else $error("reset soon after internal reset");
  a_illegal_cause:
    assert property (illegal_opcode_reset |-> $past(sys_in.stop_exec))
      else $error("illegal opcode reset without stop");
  a_illegal_once:
    assert property (illegal_opcode_reset |=> !illegal_opcode_reset)
      else $error("illegal opcode reset too long");
  a_vector_read:
    assert property (psel && penable && !pwrite && paddr[17:2] == `CWT_IDX_SERVICE
      |-> prdata == {24'h0, reset_vector_low})
      else $error("service read not vector byte");
endmodule // cwt_watchdog_properties

bind cwt_watchdog cwt_watchdog_properties #(.OSC_DIV(OSC_DIV), .POR_DELAY(POR_DELAY)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .sys_in, .reset_vector_low,
  .reset_pin_out, .reset_pin_oe, .watchdog_reset, .illegal_opcode_reset);

/* test_cop_watchdog_timer.sv */
`timescale 1ns/100ps
`include "cwt_params.svh"
`define CK(nm, ex, sn) begin n_checks++; if ((ex) !== (sn)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, sn); end end

module test_cop_watchdog_timer;
  import cwt_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic irq_hv_pin = 1'b0, rst_hv_pin = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, q;
  logic [7:0] reset_vector_low = 8'h5a;
  cwt_sys_t sys_in = 7'h0;
  wire [31:0] prdata;
  wire pready, pslverr, reset_pin_out, reset_pin_oe, watchdog_reset, illegal_opcode_reset;
  int n_rise, pulse_len, n_fail = 0, n_checks = 0, n, k, r0;

  initial forever #20 pclk = ~pclk;

  cwt_watchdog #(.POR_DELAY(16)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sys_in, .reset_vector_low, .irq_hv_pin,
    .rst_hv_pin, .reset_pin_out, .reset_pin_oe, .watchdog_reset, .illegal_opcode_reset);
  cwt_sys_model m_u (.pclk, .presetn, .reset_pin_out, .reset_pin_oe, .n_rise, .pulse_len);

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task bus(input logic w, input logic [17:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  task irst;
    @(posedge pclk);
    sys_in.internal_reset <= 1'b1;
    @(posedge pclk);
    sys_in.internal_reset <= 1'b0;
  endtask

  // Cycles from the call until the reset logic sees the pin fall.
  task wait_rise;
    n = 0;
    r0 = n_rise;
    while (n_rise == r0 && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
    `CK("rise", 1'b1, n >= `CWT_TIMEOUT_SHORT - 16 && n <= `CWT_TIMEOUT_SHORT + 4)
    if (n_rise == r0)
      stop_test();
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b1, 18'h3fffc, 32'h0);
    bus(1'b0, 18'h4, 32'h0);
    `CK("config", 32'h0, q)
    bus(1'b0, 18'h3fffc, 32'h0);
    `CK("vector", {24'h0, reset_vector_low}, q)
    bus(1'b0, 18'h100, 32'h0);
    `CK("unmapped", 1'b1, e)
    repeat (8500) @(posedge pclk);
    `CK("long", 0, n_rise)
    bus(1'b1, 18'h4, 32'h1);
    bus(1'b1, 18'h4, 32'h2);
    bus(1'b0, 18'h4, 32'h0);
    `CK("lock", 32'h1, q)
    bus(1'b1, 18'h3fffc, 32'h0);
    wait_rise();
    repeat (40) @(posedge pclk);
    `CK("pulse", `CWT_RST_PULSE, pulse_len)
    bus(1'b0, 18'h8, 32'h0);
    `CK("flag", 1'b1, q[0])
    bus(1'b1, 18'h8, 32'h1);
    bus(1'b0, 18'h8, 32'h0);
    `CK("flag clear", 1'b0, q[0])
    irst();
    bus(1'b1, 18'h4, 32'h1);
    r0 = n_rise;
    for (k = 0; k < 2; k++)
    begin
      repeat (6000) @(posedge pclk);
      bus(1'b1, 18'h3fffc, 32'hff);
    end
    `CK("kept", r0, n_rise)
    wait_rise();
    repeat (40) @(posedge pclk);
    irst();
    @(posedge pclk);
    sys_in.stop_exec <= 1'b1;
    @(posedge pclk);
    sys_in.stop_exec <= 1'b0;
    @(negedge pclk);
    `CK("illegal", 1'b1, illegal_opcode_reset)
    // Stop enabled: a stop is legal, and stop mode holds the prescaler cleared.
    irst();
    bus(1'b1, 18'h4, 32'h4);
    repeat (300) @(posedge pclk);
    sys_in.stop_exec <= 1'b1;
    @(posedge pclk);
    sys_in.stop_exec <= 1'b0;
    sys_in.stop_mode <= 1'b1;
    @(negedge pclk);
    `CK("legal stop", 1'b0, illegal_opcode_reset)
    repeat (20) @(posedge pclk);
    bus(1'b0, 18'h8, 32'h0);
    `CK("stop clear", 12'h000, q[27:16])
    sys_in.stop_mode <= 1'b0;
    repeat (300) @(posedge pclk);
    sys_in.vector_fetch <= 1'b1;
    @(posedge pclk);
    sys_in.vector_fetch <= 1'b0;
    bus(1'b0, 18'h8, 32'h0);
    `CK("fetch clear", 1'b1, q[27:16] < 12'h008)
    // Causes: disable bit, monitor with high voltage, break, blank vectors.
    for (k = 0; k < 4; k++)
    begin
      irst();
      bus(1'b1, 18'h4, k == 0 ? 32'h3 : 32'h1);
      irq_hv_pin <= (k == 1);
      rst_hv_pin <= (k == 2);
      sys_in.break_active <= (k == 2);
      sys_in.vectors_blank <= (k == 3);
      repeat (4) @(posedge pclk);
      sys_in.monitor_entry <= (k == 1 || k == 3);
      @(posedge pclk);
      sys_in.monitor_entry <= 1'b0;
      r0 = n_rise;
      repeat (8500) @(posedge pclk);
      bus(1'b0, 18'h8, 32'h0);
      `CK("quiet", r0, n_rise)
      `CK("enabled", 1'b0, q[2])
      irq_hv_pin <= 1'b0;
      rst_hv_pin <= 1'b0;
      sys_in.break_active <= 1'b0;
      sys_in.vectors_blank <= 1'b0;
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, 18'h8, 32'h0);
    `CK("por enable", 1'b1, q[2])
    // Without the power-up clear the prescaler would read 28 here.
    repeat (24) @(posedge pclk);
    bus(1'b0, 18'h8, 32'h0);
    `CK("por clear", 1'b1, q[27:16] < 12'h010)
    stop_test();
  end
endmodule // test_cop_watchdog_timer
